// ===== hdl/hpm_host_port.sv
// Overview of operation
// - Straps caught at reset set select field: 00 I2C, 01 serial, 10 UART, 11 master.
// - In master mode the upper strap pin drives the EEPROM clock out.
// - In master mode the lower strap pin is the open-drain EEPROM data.
// - Serial input bits are shifted in on the shift clock rising edge.
// - Edge select high updates serial output on falling edge, low on rising.
// - In I2C target mode three shared pins give the low address bits.
// - In UART mode the serial input pin is the receive line.
// - Lock output is high while the phase loop is locked.
// - Pending interrupts reach the host on a tri-state request output.
// - Read data leaves on the serial output at the selected edge.
// - In UART mode the serial output pin is the transmit line.
`timescale 1ns/10ps
`default_nettype none
module hpm_host_port (
   input  wire logic                 clk_sys_in,
   input  wire logic                 arst_n_in,
   input  wire logic                 shift_clk_in,
   input  wire logic                 eeprom_master_clock_pin_in,
   output var  logic                 eeprom_master_clock_pin_out,
   output var  logic                 eeprom_master_clock_pin_oe_out,
   input  wire logic                 eeprom_master_data_pin_in,
   output var  logic                 eeprom_master_data_pin_out,
   output var  logic                 eeprom_master_data_pin_oe_out,
   input  wire logic                 serial_in_pin_in,
   input  wire logic                 shift_edge_select_in,
   input  wire logic                 chip_select_n_in,
   input  wire logic                 serial_out_pin_in,
   output var  logic                 serial_out_pin_out,
   output var  logic                 serial_out_pin_oe_out,
   input  wire logic                 loop_lock_in,
   output var  logic                 loop_lock_indicator_out,
   input  wire logic                 irq_pending_in,
   output var  logic                 irq_req_n_out,
   output var  logic                 irq_req_oe_out,
   output var  logic [1:0]           host_port_select_field_out,
   output var  logic                 straps_latched_out,
   output var  logic [2:0]           i2c_target_addr_out,
   input  wire logic                 i2c_sda_drive_low_in,
   output var  logic                 i2c_sda_out,
   output var  logic                 uart_rx_data_out,
   input  wire logic                 uart_tx_data_in,
   input  wire logic                 eeprom_run_in,
   input  wire logic                 eeprom_sda_drive_low_in,
   output var  logic                 eeprom_sda_out,
   output var  logic                 wr_strobe_out,
   output var  logic [hpm_pkg::ADDR_W-1:0] wr_addr_out,
   output var  logic [hpm_pkg::DATA_W-1:0] wr_data_out
);
   import hpm_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] meta;
      logic [5:0] pins;
      logic [1:0] settle;
      logic       latched;
      logic [1:0] sel;
      logic       wt_meta;
      logic       wt_sync;
      logic       wt_prev;
      logic       wr_stb;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic [7:0] echo;
      logic       lock;
      logic       irq_pend;
      logic       irq_oe;
      logic [2:0] i2c_addr;
      logic       uart_rx;
      logic       i2c_sda;
      logic       eep_sda;
      logic [7:0] div;
      logic       scl;
      logic       scl_oe;
      logic       sda_oe;
      logic       so_val;
      logic       so_oe;
   } hpm_sys_t;

   hpm_sys_t   r_reg;
   hpm_sys_t   r_next;
   hpm_link_if lnk ();

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   function automatic logic in_mode(input logic       latched,
                                    input logic [1:0] sel,
                                    input hpm_mode_t  mode);
      in_mode = latched && (sel == mode);
   endfunction

   // ----------------------------------------------------------------
   // Shift clock domain
   // ----------------------------------------------------------------
   // The pins below belong to the shift clock domain and are used raw
   assign lnk.shift_en    = in_mode(r_reg.latched, r_reg.sel,
                                    HPM_MODE_SERIAL);
   assign lnk.serial_in_pin         = serial_in_pin_in;
   assign lnk.edge_sel    = shift_edge_select_in;
   assign lnk.cs_n        = chip_select_n_in;
   assign lnk.echo_word   = r_reg.echo;
   assign lnk.status_word = {r_reg.sel, r_reg.lock, r_reg.irq_pend,
                             r_reg.latched, 3'h0};

   hpm_shift_link u_shift (
      .shift_clk_in (shift_clk_in),
      .arst_n_in    (arst_n_in),
      .lnk          (lnk.link_side)
   );

   // ----------------------------------------------------------------
   // System clock next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next = r_reg;

      // Two-stage pin synchronisers
      r_next.meta = {serial_out_pin_in, chip_select_n_in,
                     shift_edge_select_in, serial_in_pin_in,
                     eeprom_master_clock_pin_in,
                     eeprom_master_data_pin_in};
      r_next.pins = r_reg.meta;

      // Straps caught once the synchronisers have filled
      if (!r_reg.latched) begin
         if (r_reg.settle == STRAP_SETTLE) begin
            r_next.sel     = {r_reg.pins[LANE_MODE1],
                              r_reg.pins[LANE_MODE0]};
            r_next.latched = 1'b1;
         end else begin
            r_next.settle = r_reg.settle + 2'h1;
         end
      end

      // Written words from the shift domain, toggle handshake
      r_next.wt_meta = lnk.wr_tgl;
      r_next.wt_sync = r_reg.wt_meta;
      r_next.wt_prev = r_reg.wt_sync;
      r_next.wr_stb  = r_reg.wt_sync ^ r_reg.wt_prev;
      if (r_reg.wt_sync ^ r_reg.wt_prev) begin
         r_next.wr_addr = lnk.wr_addr;
         r_next.wr_data = lnk.wr_data;
         r_next.echo    = lnk.wr_data;
      end

      // Lock and interrupt request
      r_next.lock     = loop_lock_in;
      r_next.irq_pend = irq_pending_in;
      r_next.irq_oe   = irq_pending_in;

      // I2C target address straps
      r_next.i2c_addr = 3'h0;
      if (in_mode(r_reg.latched, r_reg.sel, HPM_MODE_I2C_TGT)) begin
         r_next.i2c_addr = {r_reg.pins[LANE_SDI], r_reg.pins[LANE_EDGE],
                            r_reg.pins[LANE_CS]};
      end

      // UART receive idles high outside UART mode
      r_next.uart_rx = 1'b1;
      if (in_mode(r_reg.latched, r_reg.sel, HPM_MODE_UART)) begin
         r_next.uart_rx = r_reg.pins[LANE_SDI];
      end
      r_next.i2c_sda = r_reg.pins[LANE_SDO];
      r_next.eep_sda = r_reg.pins[LANE_MODE0];

      // EEPROM master clock divider, parked high while idle
      r_next.scl_oe = 1'b0;
      r_next.sda_oe = 1'b0;
      if (in_mode(r_reg.latched, r_reg.sel, HPM_MODE_I2C_MST)) begin
         r_next.scl_oe = 1'b1;
         r_next.sda_oe = eeprom_sda_drive_low_in;
         if (!eeprom_run_in) begin
            r_next.div = 8'h00;
            r_next.scl = 1'b1;
         end else if (r_reg.div == EEP_SCL_HALF_CYC - 8'h01) begin
            r_next.div = 8'h00;
            r_next.scl = ~r_reg.scl;
         end else begin
            r_next.div = r_reg.div + 8'h01;
         end
      end else begin
         r_next.div = 8'h00;
         r_next.scl = 1'b1;
      end

      // Shared output pin outside serial mode
      r_next.so_val = 1'b0;
      r_next.so_oe  = 1'b0;
      if (in_mode(r_reg.latched, r_reg.sel, HPM_MODE_UART)) begin
         r_next.so_val = uart_tx_data_in;
         r_next.so_oe  = 1'b1;
      end else if (in_mode(r_reg.latched, r_reg.sel,
                           HPM_MODE_I2C_TGT)) begin
         r_next.so_oe = i2c_sda_drive_low_in;
      end
   end

   // ----------------------------------------------------------------
   // System clock registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r_reg          <= '0;
         r_reg.sel      <= SEL_RESET_VAL;
         r_reg.meta     <= PIN_RESET_VAL;
         r_reg.pins     <= PIN_RESET_VAL;
         r_reg.scl      <= 1'b1;
         r_reg.uart_rx  <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Serial mode hands the pin to the shift-domain flops; the mux is
   // static once the mode is caught, so no glitch reaches the host
   always_comb begin
      if (lnk.shift_en) begin
         serial_out_pin_out    = lnk.so;
         serial_out_pin_oe_out = lnk.so_oe;
      end else begin
         serial_out_pin_out    = r_reg.so_val;
         serial_out_pin_oe_out = r_reg.so_oe;
      end
   end

   assign eeprom_master_clock_pin_out    = r_reg.scl;
   assign eeprom_master_clock_pin_oe_out = r_reg.scl_oe;
   assign eeprom_master_data_pin_out     = 1'b0;
   assign eeprom_master_data_pin_oe_out  = r_reg.sda_oe;
   assign loop_lock_indicator_out        = r_reg.lock;
   assign irq_req_n_out                  = 1'b0;
   assign irq_req_oe_out                 = r_reg.irq_oe;
   assign host_port_select_field_out     = r_reg.sel;
   assign straps_latched_out             = r_reg.latched;
   assign i2c_target_addr_out            = r_reg.i2c_addr;
   assign i2c_sda_out                    = r_reg.i2c_sda;
   assign uart_rx_data_out               = r_reg.uart_rx;
   assign eeprom_sda_out                 = r_reg.eep_sda;
   assign wr_strobe_out                  = r_reg.wr_stb;
   assign wr_addr_out                    = r_reg.wr_addr;
   assign wr_data_out                    = r_reg.wr_data;

endmodule
`default_nettype wire

// ===== hdl/hpm_shift_link.sv
`timescale 1ns/10ps
`default_nettype none
module hpm_shift_link (
   input wire logic          shift_clk_in,
   input wire logic          arst_n_in,
   hpm_link_if.link_side     lnk
);
   import hpm_pkg::*;

   typedef struct packed {
      logic [4:0]  cnt;
      logic [14:0] sh;
      logic [7:0]  tx;
      logic        so;
      logic        so_oe;
   } hpm_frame_t;

   typedef struct packed {
      logic        tgl;
      logic [6:0]  addr;
      logic [7:0]  data;
   } hpm_hold_t;

   hpm_frame_t f_reg;
   hpm_frame_t f_next;
   hpm_hold_t  h_reg;
   hpm_hold_t  h_next;
   logic       so_fall_reg;
   logic       frame_rst_n;
   logic [6:0] addr_now;

   // ----------------------------------------------------------------
   // Frame logic
   // ----------------------------------------------------------------
   // Chip select high ends the frame; the shift clock may stop then
   assign frame_rst_n = arst_n_in & ~lnk.cs_n & lnk.shift_en;
   assign addr_now    = {f_reg.sh[5:0], lnk.serial_in_pin};

   always_comb begin
      f_next = f_reg;
      h_next = h_reg;
      if (f_reg.cnt != FRAME_BITS) begin
         f_next.sh  = {f_reg.sh[13:0], lnk.serial_in_pin};
         f_next.cnt = f_reg.cnt + 5'h01;
      end
      if (f_reg.cnt == ADDR_LAST_CNT) begin
         f_next.tx    = (addr_now == STATUS_ADDR) ? lnk.status_word
                                                  : lnk.echo_word;
         f_next.so_oe = f_reg.sh[6];
      end else if (f_reg.cnt > ADDR_LAST_CNT && f_reg.cnt < FRAME_BITS) begin
         f_next.tx = {f_reg.tx[6:0], 1'b0};
      end
      f_next.so = f_next.tx[7];
      if (f_reg.cnt == WRITE_LAST_CNT && !f_reg.sh[14]) begin
         h_next.addr = f_reg.sh[13:7];
         h_next.data = {f_reg.sh[6:0], lnk.serial_in_pin};
         h_next.tgl  = ~h_reg.tgl;
      end
   end

   always_ff @(posedge shift_clk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   // Written words stay put across frames for the system side
   always_ff @(posedge shift_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   // Half-cycle late copy for the falling-edge update option
   always_ff @(negedge shift_clk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_fall_reg <= 1'b0;
      end else begin
         so_fall_reg <= f_reg.so;
      end
   end

   assign lnk.so      = lnk.edge_sel ? so_fall_reg : f_reg.so;
   assign lnk.so_oe   = f_reg.so_oe;
   assign lnk.wr_tgl  = h_reg.tgl;
   assign lnk.wr_addr = h_reg.addr;
   assign lnk.wr_data = h_reg.data;

endmodule
`default_nettype wire

// ===== pkg/hpm_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hpm_link_if;
   logic       shift_en;
   logic [7:0] status_word;
   logic [7:0] echo_word;
   logic       serial_in_pin;
   logic       edge_sel;
   logic       cs_n;
   logic       wr_tgl;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic       so;
   logic       so_oe;

   modport sys_side (
      output shift_en, status_word, echo_word, serial_in_pin, edge_sel, cs_n,
      input  wr_tgl, wr_addr, wr_data, so, so_oe
   );
   modport link_side (
      input  shift_en, status_word, echo_word, serial_in_pin, edge_sel, cs_n,
      output wr_tgl, wr_addr, wr_data, so, so_oe
   );
endinterface
`default_nettype wire

// ===== pkg/hpm_pkg.sv
`default_nettype none
package hpm_pkg;

   // ----------------------------------------------------------------
   // Host port modes, as coded on the two strap pins
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      HPM_MODE_I2C_TGT = 2'h0,
      HPM_MODE_SERIAL  = 2'h1,
      HPM_MODE_UART    = 2'h2,
      HPM_MODE_I2C_MST = 2'h3
   } hpm_mode_t;

   localparam logic [1:0] SEL_RESET_VAL = 2'h0;

   // ----------------------------------------------------------------
   // Pin synchroniser lanes
   // ----------------------------------------------------------------
   localparam int PIN_LANES    = 6;
   localparam int LANE_MODE0   = 0;
   localparam int LANE_MODE1   = 1;
   localparam int LANE_SDI     = 2;
   localparam int LANE_EDGE    = 3;
   localparam int LANE_CS      = 4;
   localparam int LANE_SDO     = 5;
   localparam logic [5:0] PIN_RESET_VAL = 6'h00;

   // Cycles after reset release before the straps are caught
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // ----------------------------------------------------------------
   // Serial frame: read flag, 7 address bits, 8 data bits
   // ----------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam logic [4:0] FRAME_BITS     = 5'h10;
   localparam logic [4:0] ADDR_LAST_CNT  = 5'h07;
   localparam logic [4:0] WRITE_LAST_CNT = 5'h0F;
   localparam logic [6:0] STATUS_ADDR    = 7'h00;

   // Status word field positions
   localparam int STAT_SEL_LSB   = 6;
   localparam int STAT_LOCK_BIT  = 5;
   localparam int STAT_IRQ_BIT   = 4;
   localparam int STAT_LATCH_BIT = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int EEP_SCL_HALF_NS   = 2500;
   localparam logic [7:0] EEP_SCL_HALF_CYC =
      8'((EEP_SCL_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

endpackage
`default_nettype wire

// ===== testbench/hpm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hpm_host_model (
   output var  logic sclk_out,
   output var  logic cs_n_out,
   output var  logic sdi_out,
   output var  logic edge_out,
   input  wire logic sdo_in
);
   // Shift clock stands low between frames; 48 ns period
   initial begin
      sclk_out = 1'b0;
      {sdi_out, edge_out, cs_n_out} = 3'h1;
   end
   task automatic set_pins(input logic [2:0] v);
      {sdi_out, edge_out, cs_n_out} = v;
   endtask
   task automatic xfer(input logic rd, input logic es, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [15:0] w;
      w = {rd, a, d};
      q = 8'h00;
      edge_out = es;
      #24;
      cs_n_out = 1'b0;
      for (int k = 1; k <= 16; k++) begin
         sdi_out = w[16-k];
         #24;
         if (es && k >= 9)
            q[16-k] = sdo_in;
         sclk_out = 1'b1;
         #24;
         if (!es && k >= 8 && k < 16)
            q[15-k] = sdo_in;
         sclk_out = 1'b0;
      end
      #24;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== testbench/hpm_host_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module hpm_host_port_chk (
   input wire logic       clk_sys_in,
   input wire logic       arst_n_in,
   input wire logic       chip_select_n_in,
   input wire logic       serial_in_pin_in,
   input wire logic       serial_out_pin_out,
   input wire logic       serial_out_pin_oe_out,
   input wire logic       uart_tx_data_in,
   input wire logic       uart_rx_data_out,
   input wire logic       loop_lock_in,
   input wire logic       loop_lock_indicator_out,
   input wire logic       irq_pending_in,
   input wire logic       irq_req_n_out,
   input wire logic       irq_req_oe_out,
   input wire logic [1:0] host_port_select_field_out,
   input wire logic       straps_latched_out,
   input wire logic [2:0] i2c_target_addr_out,
   input wire logic       eeprom_sda_drive_low_in,
   input wire logic       eeprom_master_data_pin_out,
   input wire logic       eeprom_master_data_pin_oe_out,
   input wire logic       eeprom_master_clock_pin_oe_out,
   input wire logic       wr_strobe_out
);
   logic [2:0] live_reg;
   wire        live = (live_reg == 3'h7);
   wire  [1:0] sel  = host_port_select_field_out;
   // Outputs lag reset release through the sync stage, so wait first
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         live_reg <= 3'h0;
      else if (!live)
         live_reg <= live_reg + 3'h1;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   lock_follow_a: assert property (
      live |-> loop_lock_indicator_out == $past(loop_lock_in))
      else $error("lock output wrong");
   irq_drive_a: assert property (
      live && $past(irq_pending_in) |-> irq_req_oe_out && !irq_req_n_out)
      else $error("irq not driven");
   irq_float_a: assert property (
      live && !$past(irq_pending_in) |-> !irq_req_oe_out)
      else $error("irq not floating");
   sel_hold_a: assert property (
      live && $past(straps_latched_out) |-> $stable(sel))
      else $error("select field moved");
   scl_owner_a: assert property (
      eeprom_master_clock_pin_oe_out |-> sel == 2'h3 && straps_latched_out)
      else $error("clock pin driven outside master mode");
   sda_drain_a: assert property (
      live && sel == 2'h3 && $past(sel) == 2'h3 |-> !eeprom_master_data_pin_out
      && eeprom_master_data_pin_oe_out == $past(eeprom_sda_drive_low_in))
      else $error("data pin not open drain");
   uart_rx_a: assert property (
      live && sel == 2'h2 |-> uart_rx_data_out == $past(serial_in_pin_in, 3))
      else $error("receive line wrong");
   uart_tx_a: assert property (
      live && sel == 2'h2 && $past(sel) == 2'h2 |-> serial_out_pin_oe_out
      && serial_out_pin_out == $past(uart_tx_data_in))
      else $error("transmit line wrong");
   addr_zero_a: assert property (
      live && sel != 2'h0 && $past(sel) != 2'h0 |-> i2c_target_addr_out == 3'h0)
      else $error("address outside target mode");
   strobe_pulse_a: assert property (
      wr_strobe_out |=> !wr_strobe_out)
      else $error("write strobe too long");
   serial_quiet_a: assert property (
      sel == 2'h1 && chip_select_n_in && $past(chip_select_n_in)
      |-> !serial_out_pin_oe_out)
      else $error("output driven outside frame");
endmodule
bind hpm_host_port hpm_host_port_chk chk_u (.clk_sys_in, .arst_n_in,
   .chip_select_n_in, .serial_in_pin_in, .serial_out_pin_out,
   .serial_out_pin_oe_out, .uart_tx_data_in, .uart_rx_data_out, .loop_lock_in,
   .loop_lock_indicator_out, .irq_pending_in, .irq_req_n_out, .irq_req_oe_out,
   .host_port_select_field_out, .straps_latched_out, .i2c_target_addr_out,
   .eeprom_sda_drive_low_in, .eeprom_master_data_pin_out,
   .eeprom_master_data_pin_oe_out, .eeprom_master_clock_pin_oe_out,
   .wr_strobe_out);
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import hpm_pkg::*;
   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   logic clk_sys_in, arst_n_in, loop_lock_in, irq_pending_in, strap_en;
   logic i2c_sda_drive_low_in, uart_tx_data_in, eeprom_run_in;
   logic eeprom_sda_drive_low_in;
   logic [1:0] strap;
   wire shift_clk_in, serial_in_pin_in, shift_edge_select_in;
   wire chip_select_n_in, serial_out_pin_out, serial_out_pin_oe_out;
   wire eeprom_master_clock_pin_out, eeprom_master_clock_pin_oe_out;
   wire eeprom_master_data_pin_out, eeprom_master_data_pin_oe_out;
   wire loop_lock_indicator_out, irq_req_n_out, irq_req_oe_out;
   wire straps_latched_out, uart_rx_data_out, wr_strobe_out;
   wire i2c_sda_out, eeprom_sda_out;
   wire [1:0] host_port_select_field_out;
   wire [2:0] i2c_target_addr_out;
   wire [ADDR_W-1:0] wr_addr_out;
   wire [DATA_W-1:0] wr_data_out;
   // Pads are pulled up, so released straps read high
   wire eeprom_master_clock_pin_in = eeprom_master_clock_pin_oe_out ?
      eeprom_master_clock_pin_out : (strap_en ? strap[1] : 1'b1);
   wire eeprom_master_data_pin_in = eeprom_master_data_pin_oe_out ?
      eeprom_master_data_pin_out : (strap_en ? strap[0] : 1'b1);
   wire serial_out_pin_in = serial_out_pin_oe_out ? serial_out_pin_out : 1'b1;
   int err_total, n_checks, n_wr;
   logic [7:0] wa, wd, q;
   hpm_host_port dut_u (
      .clk_sys_in, .arst_n_in, .shift_clk_in, .eeprom_master_clock_pin_in,
      .eeprom_master_clock_pin_out, .eeprom_master_clock_pin_oe_out,
      .eeprom_master_data_pin_in, .eeprom_master_data_pin_out,
      .eeprom_master_data_pin_oe_out, .serial_in_pin_in,
      .shift_edge_select_in, .chip_select_n_in, .serial_out_pin_in,
      .serial_out_pin_out, .serial_out_pin_oe_out, .loop_lock_in,
      .loop_lock_indicator_out, .irq_pending_in, .irq_req_n_out,
      .irq_req_oe_out, .host_port_select_field_out, .straps_latched_out,
      .i2c_target_addr_out, .i2c_sda_drive_low_in, .i2c_sda_out,
      .uart_rx_data_out, .uart_tx_data_in, .eeprom_run_in,
      .eeprom_sda_drive_low_in, .eeprom_sda_out, .wr_strobe_out,
      .wr_addr_out, .wr_data_out);
   hpm_host_model host_u (
      .sclk_out(shift_clk_in), .cs_n_out(chip_select_n_in),
      .sdi_out(serial_in_pin_in), .edge_out(shift_edge_select_in),
      .sdo_in(serial_out_pin_in));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      if (wr_strobe_out === 1'b1) begin
         n_wr <= n_wr + 1;
         wa <= {1'b0, wr_addr_out};
         wd <= wr_data_out;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic do_reset(input logic [1:0] m);
      cyc(1);
      arst_n_in <= 1'b0;
      strap <= m;
      strap_en <= 1'b1;
      cyc(4);
      arst_n_in <= 1'b1;
      cyc(10);
      strap_en <= 1'b0;
      cyc(6);
      @(negedge clk_sys_in);
      chk({7'h0, straps_latched_out}, 8'h01);
      chk({6'h0, host_port_select_field_out}, {6'h0, m});
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_target;
      do_reset(2'h0);
      host_u.set_pins(3'h5);
      cyc(6);
      i2c_sda_drive_low_in <= 1'b1;
      @(negedge clk_sys_in);
      chk({5'h0, i2c_target_addr_out}, 8'h05);
      // Pin level comes back through the two-stage sync
      cyc(4);
      @(negedge clk_sys_in);
      chk({6'h0, serial_out_pin_oe_out, i2c_sda_out}, 8'h02);
      cyc(1);
      i2c_sda_drive_low_in <= 1'b0;
      cyc(4);
      @(negedge clk_sys_in);
      chk({6'h0, serial_out_pin_oe_out, i2c_sda_out}, 8'h01);
   endtask
   task automatic t_serial;
      logic [14:0] tbl [2] = '{{7'h7F, 8'h00}, {7'h01, 8'hFF}};
      do_reset(2'h1);
      host_u.set_pins(3'h1);
      foreach (tbl[i]) begin
         host_u.xfer(1'b0, 1'b0, tbl[i][14:8], tbl[i][7:0], q);
         cyc(12);
         @(negedge clk_sys_in);
         chk(8'(n_wr), 8'(i + 1));
         chk(wa, {1'b0, tbl[i][14:8]});
         chk(wd, tbl[i][7:0]);
      end
      for (int es = 0; es < 2; es++) begin
         host_u.xfer(1'b1, 1'(es), 7'h01, 8'h00, q);
         chk(q, 8'hFF);
         host_u.xfer(1'b1, 1'(es), 7'h00, 8'h00, q);
         chk(q, 8'h68);
      end
      chk({7'h0, eeprom_master_clock_pin_oe_out}, 8'h00);
   endtask
   task automatic t_lock_irq;
      cyc(1);
      loop_lock_in <= 1'b0;
      irq_pending_in <= 1'b1;
      cyc(3);
      @(negedge clk_sys_in);
      chk({7'h0, loop_lock_indicator_out}, 8'h00);
      chk({6'h0, irq_req_oe_out, irq_req_n_out}, 8'h02);
      cyc(1);
      loop_lock_in <= 1'b1;
      irq_pending_in <= 1'b0;
      cyc(3);
      @(negedge clk_sys_in);
      chk({7'h0, loop_lock_indicator_out}, 8'h01);
      chk({7'h0, irq_req_oe_out}, 8'h00);
   endtask
   task automatic t_uart;
      do_reset(2'h2);
      for (int b = 0; b < 2; b++) begin
         host_u.set_pins({1'(b), 2'h1});
         cyc(1);
         uart_tx_data_in <= 1'(b);
         cyc(6);
         @(negedge clk_sys_in);
         chk({7'h0, uart_rx_data_out}, 8'(b));
         chk({6'h0, serial_out_pin_oe_out, serial_out_pin_out},
             8'(2 + b));
      end
   endtask
   task automatic t_master;
      int n;
      logic v;
      do_reset(2'h3);
      cyc(1);
      eeprom_run_in <= 1'b1;
      eeprom_sda_drive_low_in <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         n = 0;
         v = eeprom_master_clock_pin_out;
         while (eeprom_master_clock_pin_out === v && n < 300) begin
            @(negedge clk_sys_in);
            n++;
         end
      end
      chk(8'(n), EEP_SCL_HALF_CYC);
      chk({5'h0, eeprom_master_clock_pin_oe_out, eeprom_master_data_pin_in,
           eeprom_sda_out}, 8'h04);
      cyc(1);
      eeprom_sda_drive_low_in <= 1'b0;
      eeprom_run_in <= 1'b0;
      cyc(4);
      @(negedge clk_sys_in);
      chk({5'h0, eeprom_master_clock_pin_out, eeprom_master_data_pin_in,
           eeprom_sda_out}, 8'h07);
   endtask
   initial begin
      {arst_n_in, strap_en, strap, i2c_sda_drive_low_in} = 5'h0;
      {irq_pending_in, uart_tx_data_in, eeprom_run_in} = 3'h0;
      eeprom_sda_drive_low_in = 1'b0;
      loop_lock_in = 1'b1;
      {err_total, n_checks} = 64'h0;
      t_target();
      t_serial();
      t_lock_irq();
      t_uart();
      t_master();
      final_report();
   end
   initial begin
      #200us;
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
